// ==== hdl/scr_cmd_decode.sv ====
// Decoder for configuration tool resume commands into a per-connection mask
`timescale 1ns/100ps
`default_nettype none
module scr_cmd_decode #(
    parameter int NUM_CONN = 32,
    parameter int IDX_W = 5
) (
    // Command strobes
    input wire logic i_resume_one,
    input wire logic [IDX_W-1:0] i_resume_idx,
    input wire logic i_resume_all,
    // Decoded masks
    output logic [NUM_CONN-1:0] o_one_mask,
    output logic [NUM_CONN-1:0] o_all_mask
);
    // One-hot for a single resume, all ones for resume-all
    always_comb begin
        o_one_mask = '0;
        if (i_resume_one && (int'(i_resume_idx) < NUM_CONN)) begin
            o_one_mask[i_resume_idx] = 1'b1;
        end
        o_all_mask = {NUM_CONN{i_resume_all}};
    end
endmodule
`default_nettype wire

// ==== hdl/scr_defs.svh ====
// Constants for the safety connection timeout recovery supervisor
// Operation
// - Version 1.0 or later: user chooses stop or continue after a connection timeout.
// - Older version: always continue, automatic reconnection, no stop option.
// - Automatic mode: keep retrying a timed-out connection, resume without user action.
// - Stop-failed-only mode: hold failed connection stopped, others keep running.
// - Stop-failed-only mode: restart on own flag edge or restart command.
// - Stop-all mode: any timeout halts traffic with every slave.
// - Stop-all mode: a single-connection restart is refused; only all-restart resumes.
// - Single resume command restarts only the selected errored connection.
// - Resume-all command restarts every stopped connection.
// - Restart flags act on their low-to-high edge only, never on level.
// - Timeout drops the connection and drives its data to safe state.
// - Up to 32 master-side connections are tracked on version 1.0 or later.
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH
`define SCR_NUM_CONN 32
`define SCR_NUM_CONN_OLD 16
`define SCR_IDX_W 5
`define SCR_MODE_W 2
`define SCR_RST_MODE 2'h0
`endif

// ==== hdl/scr_edge_det.sv ====
// Rising edge detector for the per-connection restart flags
`timescale 1ns/100ps
`default_nettype none
module scr_edge_det #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Level in, edge out
    input wire logic [WIDTH-1:0] i_level,
    output logic [WIDTH-1:0] o_rise
);
    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] nxt_prev;

    // Previous level; held high through reset so a flag high at release is no edge
    always_comb begin
        nxt_prev = i_level;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            prev_ff <= '1;
        end else begin
            prev_ff <= nxt_prev;
        end
    end

    assign o_rise = i_level & ~prev_ff;
endmodule
`default_nettype wire

// ==== hdl/scr_pkg.sv ====
// Types of the safety connection timeout recovery supervisor
package scr_pkg;
    // Recovery mode after a connection timeout
    typedef enum logic [1:0] {
        SCR_MODE_AUTO = 2'h0,
        SCR_MODE_STOP_ONE = 2'h1,
        SCR_MODE_STOP_ALL = 2'h3
    } scr_mode_t;
endpackage

// ==== hdl/scr_supervisor.sv ====
// Top: per-connection stop/run supervision after safety connection timeouts
`timescale 1ns/100ps
`default_nettype none
`include "scr_defs.svh"
module scr_supervisor
    import scr_pkg::*;
#(
    parameter int NUM_CONN = `SCR_NUM_CONN,
    parameter int IDX_W = `SCR_IDX_W
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Configuration
    input wire logic i_unit_v1,
    input wire logic [1:0] i_recovery_mode,
    input wire logic [NUM_CONN-1:0] i_conn_enable,
    // Timeout events from the expected_packet_interval timers
    input wire logic [NUM_CONN-1:0] i_timeout,
    // Restart flags from the user logic
    input wire logic [NUM_CONN-1:0] i_restart_flag,
    // Configuration tool commands
    input wire logic i_resume_one,
    input wire logic [IDX_W-1:0] i_resume_idx,
    input wire logic i_resume_all,
    // Status and control out
    output logic [NUM_CONN-1:0] o_conn_stopped,
    output logic [NUM_CONN-1:0] o_conn_run,
    output logic [NUM_CONN-1:0] o_safe_state,
    output logic [NUM_CONN-1:0] o_reconnect_req,
    output logic o_any_stopped
);
    // Elaboration check on connection count
    if (NUM_CONN < 1 || NUM_CONN > `SCR_NUM_CONN || (1 << IDX_W) < NUM_CONN) begin : g_chk
        $error("scr_supervisor: NUM_CONN or IDX_W out of range");
    end

    logic [NUM_CONN-1:0] rise;
    logic [NUM_CONN-1:0] one_mask;
    logic [NUM_CONN-1:0] all_mask;
    logic [NUM_CONN-1:0] lim_mask;
    logic [NUM_CONN-1:0] en;
    scr_mode_t mode;
    logic [NUM_CONN-1:0] stop_ff;
    logic [NUM_CONN-1:0] nxt_stop;
    logic [NUM_CONN-1:0] down_ff;
    logic [NUM_CONN-1:0] nxt_down;
    logic [NUM_CONN-1:0] restart;
    logic all_flags_rise;
    logic any_to;

    scr_edge_det #(.WIDTH(NUM_CONN)) u_edge (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_level(i_restart_flag),
        .o_rise(rise)
    );

    scr_cmd_decode #(.NUM_CONN(NUM_CONN), .IDX_W(IDX_W)) u_cmd (
        .i_resume_one(i_resume_one),
        .i_resume_idx(i_resume_idx),
        .i_resume_all(i_resume_all),
        .o_one_mask(one_mask),
        .o_all_mask(all_mask)
    );

    // Older units track fewer connections
    for (genvar g = 0; g < NUM_CONN; g++) begin : g_lim
        assign lim_mask[g] = i_unit_v1 || (g < `SCR_NUM_CONN_OLD);
    end
    assign en = i_conn_enable & lim_mask;

    // Older units are forced into automatic recovery
    always_comb begin
        if (!i_unit_v1) begin
            mode = SCR_MODE_AUTO;
        end else begin
            case (i_recovery_mode)
                2'h1: mode = SCR_MODE_STOP_ONE;
                2'h3: mode = SCR_MODE_STOP_ALL;
                default: mode = SCR_MODE_AUTO;
            endcase
        end
    end

    // Stop-all accepts only a restart covering every enabled connection
    assign all_flags_rise = ((rise & en) == en) && (en != '0);
    assign any_to = |(i_timeout & en);

    // Restart sources by mode
    always_comb begin
        case (mode)
            SCR_MODE_STOP_ONE: restart = rise | one_mask | all_mask;
            SCR_MODE_STOP_ALL: restart = (all_flags_rise || i_resume_all) ? '1 : '0;
            default: restart = '0;
        endcase
    end

    // Stopped state: a new timeout wins over a restart in the same cycle
    always_comb begin
        nxt_stop = '0;
        case (mode)
            SCR_MODE_STOP_ONE: begin
                nxt_stop = ((stop_ff & ~restart) | i_timeout) & en;
            end
            SCR_MODE_STOP_ALL: begin
                if (any_to) begin
                    nxt_stop = en;
                end else begin
                    nxt_stop = stop_ff & ~restart & en;
                end
            end
            default: nxt_stop = '0;
        endcase
    end

    // Link down until its connection is restarted, or for one cycle in automatic mode; timeout always drops it
    always_comb begin
        nxt_down = ((down_ff & ~restart) | i_timeout) & en;
        if (mode == SCR_MODE_AUTO) begin
            nxt_down = i_timeout & en;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            stop_ff <= '0;
            down_ff <= '0;
        end else begin
            stop_ff <= nxt_stop;
            down_ff <= nxt_down;
        end
    end

    // Outputs: stopped or freshly timed-out connections hold safe data
    assign o_conn_stopped = stop_ff;
    assign o_conn_run = en & ~stop_ff & ~down_ff;
    assign o_safe_state = stop_ff | down_ff | ~en;
    assign o_reconnect_req = en & ~stop_ff & down_ff;
    assign o_any_stopped = |stop_ff;

    // Checks
    property p_stop_all;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_STOP_ALL && any_to) |=> (o_conn_stopped == $past(en));
    endproperty
    a_stop_all: assert property (p_stop_all) else $error("stop-all did not stop all");

    property p_stop_one;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_STOP_ONE)
            |=> ((o_conn_stopped & ~$past(stop_ff)) == $past(i_timeout & en & ~stop_ff));
    endproperty
    a_stop_one: assert property (p_stop_one) else $error("stop-one stopped wrong set");

    property p_auto;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_AUTO) [*2] |-> (stop_ff == '0);
    endproperty
    a_auto: assert property (p_auto) else $error("auto mode holds a stop");

    property p_old;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_unit_v1 |-> (mode == SCR_MODE_AUTO);
    endproperty
    a_old: assert property (p_old) else $error("old unit not automatic");

    sequence s_one_resume;
        mode == SCR_MODE_STOP_ALL && i_resume_one && !i_resume_all && !all_flags_rise && !any_to;
    endsequence
    property p_no_single;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_one_resume |=> (o_conn_stopped == ($past(stop_ff) & $past(en)));
    endproperty
    a_no_single: assert property (p_no_single) else $error("single restart in stop-all");

    property p_resume_all;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode != SCR_MODE_AUTO && i_resume_all && (i_timeout & en) == '0) |=> (o_conn_stopped == '0);
    endproperty
    a_resume_all: assert property (p_resume_all) else $error("resume-all left a stop");

    // Disabled connections are never held stopped
    property p_no_stop_dis;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (o_conn_stopped & ~$past(i_conn_enable)) == '0;
    endproperty
    a_no_stop_dis: assert property (p_no_stop_dis) else $error("disabled link stopped");

    // Older units serve only the lower connections
    property p_old_lim;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        !i_unit_v1 |-> ((o_conn_run >> `SCR_NUM_CONN_OLD) == '0);
    endproperty
    a_old_lim: assert property (p_old_lim) else $error("old unit ran upper link");

    // Automatic mode: a timeout starts a retry, never a stop
    property p_auto_retry;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_AUTO) |=> (($past(i_timeout & en) & en & ~o_reconnect_req) == '0);
    endproperty
    a_auto_retry: assert property (p_auto_retry) else $error("auto mode did not retry");

    // Automatic mode: the retry ends without user action once timeouts cease
    property p_auto_back;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_AUTO && (i_timeout & en) == '0) |=> (o_reconnect_req == '0);
    endproperty
    a_auto_back: assert property (p_auto_back) else $error("auto retry did not end");

    // Stop-one: a resume command clears its connection and lets traffic run
    sequence s_one_cmd;
        mode == SCR_MODE_STOP_ONE && i_resume_one;
    endsequence
    property p_one_cmd;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_one_cmd |=> ((o_conn_stopped & $past(one_mask & ~i_timeout)) == '0);
    endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("resume left link stopped");

    property p_one_run;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_one_cmd |=> (((o_conn_run | ~en) & $past(one_mask & ~i_timeout))
            == $past(one_mask & ~i_timeout));
    endproperty
    a_one_run: assert property (p_one_run) else $error("resumed link not running");

    // Stop-one: a flag edge clears its connection unless a timeout lands with it
    property p_flag_rise;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_STOP_ONE && rise != '0)
            |=> ((o_conn_stopped & $past(rise & ~i_timeout)) == '0);
    endproperty
    a_flag_rise: assert property (p_flag_rise) else $error("flag edge ignored");

    // Stop-one: stopped links not named by a restart stay stopped
    property p_one_keep;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_STOP_ONE && !i_resume_all)
            |=> ((o_conn_stopped & $past(stop_ff & en & ~rise & ~one_mask))
                 == $past(stop_ff & en & ~rise & ~one_mask));
    endproperty
    a_one_keep: assert property (p_one_keep) else $error("unnamed link restarted");

    // Stop-one: a restart never touches a running link
    property p_no_effect;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_STOP_ONE) |=> ((o_conn_stopped & ~$past(stop_ff | i_timeout)) == '0);
    endproperty
    a_no_effect: assert property (p_no_effect) else $error("running link stopped");

    // Stop-all: a partial set of flag edges is refused
    sequence s_part_flags;
        mode == SCR_MODE_STOP_ALL && rise != '0 && !all_flags_rise && !i_resume_all && !any_to;
    endsequence
    property p_part_flags;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        s_part_flags |=> (o_conn_stopped == $past(stop_ff & en));
    endproperty
    a_part_flags: assert property (p_part_flags) else $error("partial flags restarted");

    // Stop-all: edges on every enabled flag together resume all links
    property p_all_flags;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode == SCR_MODE_STOP_ALL && all_flags_rise && !any_to) |=> (o_conn_stopped == '0);
    endproperty
    a_all_flags: assert property (p_all_flags) else $error("all flags did not restart");

    // Resume-all also clears the link-down marks, so data leaves safe state
    property p_resume_safe;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        (mode != SCR_MODE_AUTO && i_resume_all && (i_timeout & en) == '0)
            |=> ((o_safe_state & en) == '0);
    endproperty
    a_resume_safe: assert property (p_resume_safe) else $error("resume-all left safe data");

    // A timeout drives the data safe on the next clock, whatever the mode
    property p_safe;
        @(posedge i_core_clk) disable iff (!i_rst_n)
        ((i_timeout & en) != '0)
            |=> ((o_safe_state & $past(i_timeout & en)) == $past(i_timeout & en))
             && ((o_conn_run & $past(i_timeout & en)) == '0);
    endproperty
    a_safe: assert property (p_safe) else $error("timeout left data unsafe");

    // Per connection: a held flag never restarts, a fresh edge after a timeout does
    for (genvar c = 0; c < NUM_CONN; c++) begin : g_conn_chk
        sequence s_cut;
            mode == SCR_MODE_STOP_ONE && i_timeout[c] && en[c];
        endsequence
        sequence s_edge;
            mode == SCR_MODE_STOP_ONE && rise[c] && !i_timeout[c];
        endsequence

        property p_level;
            @(posedge i_core_clk) disable iff (!i_rst_n)
            (mode == SCR_MODE_STOP_ONE && stop_ff[c] && en[c] && i_restart_flag[c]
             && $past(i_restart_flag[c]) && !one_mask[c] && !i_resume_all)
                |=> o_conn_stopped[c];
        endproperty
        a_level: assert property (p_level) else $error("level restarted connection");

        property p_walk;
            @(posedge i_core_clk) disable iff (!i_rst_n)
            s_cut ##[1:4] s_edge |=> !o_conn_stopped[c] && (o_conn_run[c] || !en[c]);
        endproperty
        a_walk: assert property (p_walk) else $error("flag edge did not restart");
    end
endmodule
`default_nettype wire

// ==== verification/scr_slave_model.sv ====
// Far-side model: packet interval expiry events per safety connection
`timescale 1ns/100ps
`default_nettype none
module scr_slave_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // Fault cause in, timeout event out
    input wire logic [31:0] i_fault,
    output logic [31:0] o_timeout
);
    logic [31:0] prev_ff;
    // One event per fault start; a lasting fault is not reported twice
    always_ff @(posedge i_core_clk) begin
        prev_ff <= i_rst_n ? i_fault : 32'h0;
        o_timeout <= i_rst_n ? (i_fault & ~prev_ff) : 32'h0;
    end
endmodule
`default_nettype wire

// ==== verification/scr_supervisor_tb_top.sv ====
// Self-checking bench for the connection timeout recovery supervisor
`timescale 1ns/100ps
`default_nettype none
module scr_supervisor_tb_top import scr_pkg::*; ;
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic unit_v1 = 1'b1;
    logic res_one = 1'b0;
    logic res_all = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [4:0] res_idx = 5'h0;
    logic [31:0] en = 32'h800000ff;
    logic [31:0] flag = 32'h0;
    logic [31:0] fault = 32'h0;
    logic [31:0] tmo, stopped, run, safe, recon;
    logic any;
    int error_cnt = 0;
    int checked = 0;

    scr_slave_model slaves (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
        .i_fault(fault), .o_timeout(tmo));
    scr_supervisor DUT (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_unit_v1(unit_v1),
        .i_recovery_mode(mode), .i_conn_enable(en), .i_timeout(tmo),
        .i_restart_flag(flag), .i_resume_one(res_one), .i_resume_idx(res_idx),
        .i_resume_all(res_all), .o_conn_stopped(stopped), .o_conn_run(run),
        .o_safe_state(safe), .o_reconnect_req(recon), .o_any_stopped(any));

    // Free-running 100 MHz clock
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end

    task finish_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask

    // Fault on one link; returns settled just after the stop is registered
    task hit(input int k);
        @(posedge i_core_clk);
        fault <= 32'h1 << k;
        @(posedge i_core_clk);
        fault <= 32'h0;
        @(posedge i_core_clk);
        #1;
    endtask

    task cmd(input logic one, input logic [4:0] idx, input logic all);
        @(posedge i_core_clk);
        res_one <= one;
        res_idx <= idx;
        res_all <= all;
        @(posedge i_core_clk);
        res_one <= 1'b0;
        res_all <= 1'b0;
        #1;
    endtask

    task set_flag(input logic [31:0] v);
        @(posedge i_core_clk);
        flag <= v;
        @(posedge i_core_clk);
        #1;
    endtask

    task cfg(input logic v1, input logic [1:0] m);
        @(posedge i_core_clk);
        unit_v1 <= v1;
        mode <= m;
    endtask

    // Recovery without stopping; a restart edge on a running link is harmless
    task t_auto(input logic v1, input logic [1:0] m);
        cfg(v1, m);
        hit(1);
        chk(stopped, 32'h0);
        chk(recon, 32'h2);
        chk({31'h0, safe[1]}, 32'h1);
        chk({31'h0, any}, 32'h0);
        chk(run, v1 ? 32'h800000fd : 32'h000000fd);
        set_flag(32'h2);
        chk(stopped, 32'h0);
        set_flag(32'h0);
    endtask

    task t_one();
        cfg(1'b1, SCR_MODE_STOP_ONE);
        hit(3);
        chk(stopped, 32'h8);
        chk(run, 32'h800000f7);
        chk({31'h0, any}, 32'h1);
        chk(recon, 32'h0);
        chk(safe, 32'h7fffff08);
        hit(4);
        cmd(1'b1, 5'h4, 1'b0);
        chk(stopped, 32'h8);
        chk(run, 32'h800000f7);
        cmd(1'b1, 5'h5, 1'b0);
        chk(stopped, 32'h8);
        set_flag(32'h8);
        chk(stopped, 32'h0);
        chk(run, 32'h800000ff);
        hit(3);
        chk(stopped, 32'h8);
        set_flag(32'h0);
        chk(stopped, 32'h8);
        hit(31);
        chk(stopped, 32'h80000008);
        cmd(1'b0, 5'h0, 1'b1);
        chk(stopped, 32'h0);
        chk({31'h0, any}, 32'h0);
        hit(6);
        set_flag(32'h40);
        chk(stopped, 32'h0);
        chk(safe, 32'h7fffff00);
    endtask

    // Whole-network stop: only an all-links restart brings traffic back
    task t_all();
        cfg(1'b1, SCR_MODE_STOP_ALL);
        hit(2);
        chk(stopped, en);
        chk(run, 32'h0);
        cmd(1'b1, 5'h2, 1'b0);
        chk(stopped, en);
        set_flag(32'h4);
        chk(stopped, en);
        set_flag(32'h0);
        set_flag(en);
        chk(stopped, 32'h0);
        chk(run, en);
        set_flag(32'h0);
        hit(5);
        cmd(1'b0, 5'h0, 1'b1);
        chk(stopped, 32'h0);
        chk(safe, ~en);
    endtask

    initial begin
        repeat (16) @(posedge i_core_clk);
        i_rst_n <= 1'b1;
        t_auto(1'b1, SCR_MODE_AUTO);
        t_auto(1'b1, 2'h2);
        t_auto(1'b0, SCR_MODE_STOP_ALL);
        t_one();
        t_all();
        finish_test();
    end

    // Hang guard: a run that overstays counts as a mismatch
    initial begin
        #200000;
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire
